// ==== rtl/nfcsr_consts.svh ====
`ifndef NFCSR_CONSTS_SVH
`define NFCSR_CONSTS_SVH
// register offsets
`define NFCSR_OFF_IRQ2 6'h05
`define NFCSR_OFF_ERR 6'h06
`define NFCSR_OFF_ST1 6'h07
`define NFCSR_OFF_ST2 6'h08
`define NFCSR_OFF_FDATA 6'h09
`define NFCSR_OFF_FLVL 6'h0a
`define NFCSR_OFF_WMARK 6'h0b
`define NFCSR_OFF_CTRL 6'h0c
// reset values
`define NFCSR_RST_WMARK 6'h08
// field positions
`define NFCSR_B_SETSEL 7
`define NFCSR_B_FLUSH 7
`define NFCSR_B_TSTOP 7
`define NFCSR_B_TSTART 6
`define NFCSR_B_IDCOPY 5
`define NFCSR_B_INIT 4
`define NFCSR_B_OVCLR 7
`define NFCSR_E_WR 7
`define NFCSR_E_TEMP 6
`define NFCSR_E_RF 5
`define NFCSR_E_OVF 4
`define NFCSR_E_COLL 3
`define NFCSR_E_CRC 2
`define NFCSR_E_PAR 1
`define NFCSR_E_PROT 0
`define NFCSR_I_MODE 3
`define NFCSR_I_ON 1
`define NFCSR_I_OFF 0
// framing value that enables the peer field check
`define NFCSR_FRAME_ACTIVE 2'h1
// nfcid length in bytes
`define NFCSR_ID_LEN 4'ha
`endif

// ==== rtl/nfcsr_fifo.sv ====
`timescale 1ns/10ps
// byte fifo storage with level count
module nfcsr_fifo #(
  parameter int DEPTH = 64
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // control
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [7:0] i_wdata,
  input wire logic i_pop,
  // status
  output logic [7:0] o_rdata,
  output logic [6:0] o_level
);
  typedef struct packed {
    logic [5:0] wp;
    logic [5:0] rp;
    logic [6:0] lvl;
  } nfcsr_fifo_s;
  nfcsr_fifo_s st_r, st_nxt;
  logic [7:0] mem [DEPTH];
  logic do_push, do_pop;

  // refused moves leave pointers alone
  assign do_push = i_push && (st_r.lvl != 7'(DEPTH));
  assign do_pop = i_pop && (st_r.lvl != 7'h00);
  assign o_level = st_r.lvl;
  assign o_rdata = mem[st_r.rp];

  // pointer update; flush wins over everything
  always_comb begin
    st_nxt = st_r;
    if (i_flush) begin
      st_nxt = '0;
    end else begin
      if (do_push) st_nxt.wp = st_r.wp + 6'h01;
      if (do_pop) st_nxt.rp = st_r.rp + 6'h01;
      st_nxt.lvl = st_r.lvl + 7'(do_push) - 7'(do_pop);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) st_r <= '0;
    else if (i_ce) st_r <= st_nxt;
  end

  // storage has no reset
  always_ff @(posedge i_ref_clk) begin
    if (i_ce && do_push && !i_flush) mem[st_r.wp] <= i_wdata;
  end
endmodule : nfcsr_fifo

// ==== rtl/nfcsr_pkg.sv ====
package nfcsr_pkg;
  // modem state codes, in documented order
  typedef enum logic [2:0] {
    MS_IDLE, MS_WAIT_START, MS_TX_WAIT, MS_SENDING,
    MS_RX_WAIT, MS_WAIT_DATA, MS_RECEIVING
  } nfcsr_modem_e;
  // receive rate
  typedef enum logic [1:0] {RATE_106, RATE_212, RATE_424} nfcsr_rate_e;
endpackage : nfcsr_pkg

// ==== rtl/nfcsr_regs.sv ====
`timescale 1ns/10ps
`include "nfcsr_consts.svh"
// Function
// - set mode flag when detector finds mode; detector runs in anticollision only
// - field appear and vanish set their interrupt flags
// - host fifo write in anticollision or tx-to-rx gap sets write error
// - overheat sets error flag and disables antenna drivers
// - peer field timing error only when a framing field equals 01
// - any write into a full fifo sets overflow error
// - collision error only at 106 kbit/s, cleared at receiver start
// - checksum error when enabled and failed, cleared at receiver start
// - parity error only at 106 kbit/s, cleared at receiver start
// - bad start of frame at 106 sets protocol error
// - byte length violation with sync detect sets protocol error for a higher rate card or in active mode above 106
// - command start clears all errors but overheat; software never sets
// - frequency ok reflects carrier within 12 to 15 MHz
// - checksum done on compute finish; zero status low while computing
// - pending bit is or of enabled interrupt flags
// - high alert compares free space and low alert compares fill against watermark
// - overheat clear works only below alarm temperature
// - three bit modem state encoding
// - 64 byte fifo, writes increment and reads decrement level
// - flush resets pointers and overflow error, reads zero
// - timer start and stop strobes, read zero
// - identifier copy pushes ten bytes then self clears
// - second irq register bit 7 chooses set or clear
module nfcsr_regs #(
  parameter int FIFO_DEPTH = 64
) (
  // clock, enable, reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // host register port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // internal engine events
  input wire logic i_mode_found,
  input wire logic i_rf_reset,
  input wire logic i_field_present,
  input wire logic i_anticollision_target_cmd,
  input wire logic i_tx_rx_gap,
  input wire logic i_overheat,
  input wire logic i_temp_below_alarm,
  input wire logic i_active_mode,
  input wire logic i_peer_field_late,
  input wire logic [1:0] i_receive_framing_sel,
  input wire logic [1:0] i_transmit_framing_sel,
  input wire logic i_int_push,
  input wire logic [7:0] i_int_data,
  input wire logic i_rx_start,
  input wire logic [1:0] i_rate,
  input wire logic i_bit_collision,
  input wire logic i_receive_checksum_enable,
  input wire logic i_crc_fail,
  input wire logic i_parity_fail,
  input wire logic i_sof_bad,
  input wire logic i_sync_detect_enable,
  input wire logic i_higher_rate_card,
  input wire logic i_byte_len_bad,
  input wire logic i_cmd_start,
  input wire logic i_freq_in_band,
  input wire logic i_checksum_compute_cmd,
  input wire logic i_crc_busy,
  input wire logic i_crc_done,
  input wire logic i_crc_zero,
  input wire logic [7:0] i_irq_enables,
  input wire logic [7:0] i_irq1_flags,
  input wire logic i_timer_running,
  input wire logic [2:0] i_modem_state,
  input wire logic [79:0] i_nfcid,
  input wire logic [2:0] i_rx_last_bits,
  // outputs to the engines
  output logic o_detector_run,
  output logic o_antenna_off,
  output logic o_timer_start,
  output logic o_timer_stop,
  output logic o_irq_pending,
  output logic o_initiator
);
  typedef struct packed {
    logic [7:0] irq2;
    logic [7:0] err;
    logic [5:0] wmark;
    logic init;
    logic ovclr_bit;
    logic idcopy;
    logic [3:0] idcnt;
    logic det_run;
    logic field_q2;
    logic field_q3;
    logic freq_q2;
    logic freq_q3;
    logic freq_ok;
    logic field_st;
    logic crc_rdy;
    logic crc_ok;
    logic t_start;
    logic t_stop;
    logic [7:0] rdata;
  } nfcsr_state_s;
  nfcsr_state_s st_r, st_nxt;
  logic field_q1_r, freq_q1_r;
  logic [6:0] level;
  logic [7:0] fifo_rd;
  logic full, host_push, id_push, any_push, host_pop, flush_w;
  logic [7:0] id_byte;

  // decode of one host address
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a == o);
  endfunction : hit

  assign full = (level == 7'(FIFO_DEPTH));
  assign host_push = i_wr && hit(i_addr, `NFCSR_OFF_FDATA);
  assign host_pop = i_rd && hit(i_addr, `NFCSR_OFF_FDATA);
  assign flush_w = i_wr && hit(i_addr, `NFCSR_OFF_FLVL) &&
    i_wdata[`NFCSR_B_FLUSH];
  assign id_push = st_r.idcopy;
  assign id_byte = i_nfcid[{st_r.idcnt, 3'h0} +: 8];
  // one writer per cycle; host wins, identifier copy waits behind it, a clashing internal byte is lost
  assign any_push = host_push || id_push || i_int_push;

  nfcsr_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_flush(flush_w),
    .i_push(any_push),
    .i_wdata(host_push ? i_wdata : (id_push ? id_byte : i_int_data)),
    .i_pop(host_pop),
    .o_rdata(fifo_rd),
    .o_level(level)
  );

  // first synchroniser stage, read only by the second
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      field_q1_r <= 1'b0;
      freq_q1_r <= 1'b0;
    end else if (i_ce) begin
      field_q1_r <= i_field_present;
      freq_q1_r <= i_freq_in_band;
    end
  end

  // next-state logic of the whole register group
  always_comb begin
    logic [7:0] e;
    logic fld;
    logic [7:0] st1, st2;
    e = st_r.err;
    fld = st_r.field_st;
    st1 = 8'h00;
    st2 = 8'h00;
    st_nxt = st_r;
    st_nxt.field_q2 = field_q1_r;
    st_nxt.field_q3 = st_r.field_q2;
    st_nxt.freq_q2 = freq_q1_r;
    st_nxt.freq_q3 = st_r.freq_q2;
    // a change is accepted once stages two and three agree
    if (st_r.field_q2 == st_r.field_q3) fld = st_r.field_q2;
    st_nxt.field_st = fld;
    if (st_r.freq_q2 == st_r.freq_q3) st_nxt.freq_ok = st_r.freq_q2;
    st_nxt.t_start = 1'b0;
    st_nxt.t_stop = 1'b0;
    // host writes to the second irq register
    if (i_wr && hit(i_addr, `NFCSR_OFF_IRQ2)) begin
      if (i_wdata[`NFCSR_B_SETSEL]) begin
        st_nxt.irq2 = st_r.irq2 | {1'b0, i_wdata[6:0]};
      end else begin
        st_nxt.irq2 = st_r.irq2 & ~{1'b0, i_wdata[6:0]};
      end
    end
    // hardware sets after host clears, so set wins
    if (st_r.det_run && i_mode_found) begin
      st_nxt.irq2[`NFCSR_I_MODE] = 1'b1;
    end
    if (fld && !st_r.field_st) st_nxt.irq2[`NFCSR_I_ON] = 1'b1;
    if (!fld && st_r.field_st) st_nxt.irq2[`NFCSR_I_OFF] = 1'b1;
    // detector stops on find and restarts on rf reset
    if (!i_anticollision_target_cmd || i_mode_found) st_nxt.det_run = 1'b0;
    else if (i_rf_reset) st_nxt.det_run = 1'b1;
    else if (i_cmd_start) st_nxt.det_run = 1'b1;
    // error clears come first so a simultaneous event still lands
    if (i_cmd_start) e = e & (8'h01 << `NFCSR_E_TEMP);
    if (i_rx_start) begin
      e[`NFCSR_E_COLL] = 1'b0;
      e[`NFCSR_E_CRC] = 1'b0;
      e[`NFCSR_E_PAR] = 1'b0;
      e[`NFCSR_E_PROT] = 1'b0;
    end
    if (flush_w) e[`NFCSR_E_OVF] = 1'b0;
    if (st_r.ovclr_bit && i_temp_below_alarm) e[`NFCSR_E_TEMP] = 1'b0;
    if (host_push && (i_anticollision_target_cmd || i_tx_rx_gap)) begin
      e[`NFCSR_E_WR] = 1'b1;
    end
    if (i_overheat) e[`NFCSR_E_TEMP] = 1'b1;
    if (i_active_mode && i_peer_field_late &&
        (i_receive_framing_sel == `NFCSR_FRAME_ACTIVE ||
         i_transmit_framing_sel == `NFCSR_FRAME_ACTIVE)) begin
      e[`NFCSR_E_RF] = 1'b1;
    end
    if (any_push && full) e[`NFCSR_E_OVF] = 1'b1;
    if (i_bit_collision && i_rate == 2'(nfcsr_pkg::RATE_106)) begin
      e[`NFCSR_E_COLL] = 1'b1;
    end
    if (i_receive_checksum_enable && i_crc_fail) e[`NFCSR_E_CRC] = 1'b1;
    if (i_parity_fail && i_rate == 2'(nfcsr_pkg::RATE_106)) begin
      e[`NFCSR_E_PAR] = 1'b1;
    end
    if (i_sof_bad && i_rate == 2'(nfcsr_pkg::RATE_106)) begin
      e[`NFCSR_E_PROT] = 1'b1;
    end
    if (i_byte_len_bad && i_sync_detect_enable && (i_higher_rate_card ||
        (i_active_mode && i_rate != 2'(nfcsr_pkg::RATE_106)))) begin
      e[`NFCSR_E_PROT] = 1'b1;
    end
    st_nxt.err = e;
    // checksum coprocessor status
    if (i_checksum_compute_cmd && i_crc_busy) begin
      st_nxt.crc_rdy = 1'b0;
      st_nxt.crc_ok = 1'b0;
    end else if (i_checksum_compute_cmd && i_crc_done) begin
      st_nxt.crc_rdy = 1'b1;
      st_nxt.crc_ok = i_crc_zero;
    end
    // identifier copy walks ten bytes then self clears
    // a host write holds the walk, so the last byte is never skipped
    if (st_r.idcopy && !host_push) begin
      if (st_r.idcnt == `NFCSR_ID_LEN - 4'h1) begin
        st_nxt.idcopy = 1'b0;
        st_nxt.idcnt = 4'h0;
      end else begin
        st_nxt.idcnt = st_r.idcnt + 4'h1;
      end
    end
    // other host writes
    if (i_wr && hit(i_addr, `NFCSR_OFF_WMARK)) st_nxt.wmark = i_wdata[5:0];
    if (i_wr && hit(i_addr, `NFCSR_OFF_ST2)) begin
      st_nxt.ovclr_bit = i_wdata[`NFCSR_B_OVCLR];
    end
    if (i_wr && hit(i_addr, `NFCSR_OFF_CTRL)) begin
      st_nxt.t_stop = i_wdata[`NFCSR_B_TSTOP];
      st_nxt.t_start = i_wdata[`NFCSR_B_TSTART];
      st_nxt.init = i_wdata[`NFCSR_B_INIT];
      if (i_wdata[`NFCSR_B_IDCOPY]) st_nxt.idcopy = 1'b1;
    end
    // read mux; strobe bits read zero
    st1 = {st_r.freq_ok, st_r.crc_ok, st_r.crc_rdy, o_irq_pending,
      i_timer_running, st_r.field_st,
      7'(FIFO_DEPTH) - level <= {1'b0, st_r.wmark},
      level <= {1'b0, st_r.wmark}};
    st2 = {st_r.ovclr_bit, 4'h0, i_modem_state};
    case (i_addr)
      `NFCSR_OFF_IRQ2: st_nxt.rdata = {1'b0, st_r.irq2[6:0]};
      `NFCSR_OFF_ERR: st_nxt.rdata = st_r.err;
      `NFCSR_OFF_ST1: st_nxt.rdata = st1;
      `NFCSR_OFF_ST2: st_nxt.rdata = st2;
      `NFCSR_OFF_FDATA: st_nxt.rdata = fifo_rd;
      `NFCSR_OFF_FLVL: st_nxt.rdata = {1'b0, level};
      `NFCSR_OFF_WMARK: st_nxt.rdata = {2'h0, st_r.wmark};
      `NFCSR_OFF_CTRL: st_nxt.rdata = {2'h0, st_r.idcopy, st_r.init,
        1'b0, i_rx_last_bits};
      default: st_nxt.rdata = 8'h00;
    endcase
  end

  // pending summary; first irq group is gated outside
  assign o_irq_pending = |(i_irq1_flags | (st_r.irq2[6:0] &
    i_irq_enables[6:0]));
  assign o_rdata = st_r.rdata;
  assign o_detector_run = st_r.det_run;
  assign o_antenna_off = st_r.err[`NFCSR_E_TEMP];
  assign o_timer_start = st_r.t_start;
  assign o_timer_stop = st_r.t_stop;
  assign o_initiator = st_r.init;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
      st_r.wmark <= `NFCSR_RST_WMARK;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // assertions
  a_flush_clears_ovf: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && flush_w && !(any_push && full)
    |=> !st_r.err[`NFCSR_E_OVF])
    else $error("overflow flag survived flush");
  a_ovf_on_full: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && any_push && full |=> st_r.err[4])
    else $error("overflow not flagged");
  a_cmd_clears_errs: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && i_cmd_start && !i_overheat && !host_push
    && !i_int_push && !id_push && !i_active_mode && !i_bit_collision
    && !i_crc_fail && !i_parity_fail && !i_sof_bad && !i_byte_len_bad
    && !(st_r.ovclr_bit && i_temp_below_alarm)
    |=> st_r.err[7:0] == ($past(st_r.err) & 8'h40))
    else $error("command start did not clear errors");
  a_temp_sticky: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && st_r.err[6] && !i_temp_below_alarm
    |=> st_r.err[6])
    else $error("overheat cleared while hot");
  a_antenna_off: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && i_overheat |=> o_antenna_off)
    else $error("antenna not disabled");
  a_field_on_irq: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && st_r.field_q2 && st_r.field_q3
    && !st_r.field_st |=> st_r.field_st && st_r.irq2[`NFCSR_I_ON])
    else $error("field on not seen");
  a_level_inc: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && host_push && !full && !host_pop
    && !flush_w |=> level == $past(level) + 7'h01)
    else $error("level did not increment");
  a_empty_read: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && host_pop && level == 7'h00 && !any_push
    |=> level == 7'h00)
    else $error("empty read moved level");
  a_timer_strobe: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) o_timer_start && i_ce |=> !o_timer_start
    || $past(i_wr))
    else $error("timer strobe stuck");
  a_mode_irq_set: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && st_r.det_run && i_mode_found
    |=> st_r.irq2[`NFCSR_I_MODE] && !st_r.det_run)
    else $error("mode found but flag not set");
  a_wr_err_set: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && host_push && i_anticollision_target_cmd
    |=> st_r.err[`NFCSR_E_WR])
    else $error("write error not flagged");
  a_rf_err_gate: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && !st_r.err[`NFCSR_E_RF] && (!i_active_mode
    || (i_receive_framing_sel != `NFCSR_FRAME_ACTIVE &&
    i_transmit_framing_sel != `NFCSR_FRAME_ACTIVE))
    |=> !st_r.err[`NFCSR_E_RF])
    else $error("peer field error outside active framing");
  a_coll_rate_gate: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && !st_r.err[`NFCSR_E_COLL] &&
    i_rate != 2'(nfcsr_pkg::RATE_106) |=> !st_r.err[`NFCSR_E_COLL])
    else $error("collision flagged at higher rate");
  a_crc_done: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) i_ce && i_checksum_compute_cmd && !i_crc_busy
    && i_crc_done |=> st_r.crc_rdy && st_r.crc_ok == $past(i_crc_zero))
    else $error("checksum status not updated");
endmodule : nfcsr_regs

// ==== sim/nfcsr_host_model.sv ====
`timescale 1ns/10ps
// host side of the register port, driven through its tasks
module nfcsr_host_model (
  // clock
  input wire logic i_ref_clk,
  // register port
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [5:0] o_addr,
  output logic [7:0] o_wdata
);
  // idle port from time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 6'h00;
    o_wdata = 8'h00;
  end
  // one write, taken at the edge after the request is raised
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d; // released data must not look valid
  endtask : wr
  // one read; data is registered at the strobe edge, taken at the next
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    @(posedge i_ref_clk);
    d = i_rdata;
  endtask : rd
endmodule : nfcsr_host_model

// ==== sim/test_nfcsr_regs.sv ====
`timescale 1ns/10ps
`include "nfcsr_consts.svh"
// register group bench: host accesses with engine events around them
module test_nfcsr_regs;
  logic i_ref_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1;
  wire i_wr, i_rd;
  wire [5:0] i_addr;
  wire [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic i_mode_found = 1'b0, i_rf_reset = 1'b0, i_field_present = 1'b0;
  logic i_anticollision_target_cmd = 1'b0, i_tx_rx_gap = 1'b0;
  logic i_overheat = 1'b0, i_temp_below_alarm = 1'b0, i_active_mode = 1'b0;
  logic i_peer_field_late = 1'b0;
  logic [1:0] i_receive_framing_sel = 2'h0, i_transmit_framing_sel = 2'h0;
  logic i_int_push = 1'b0, i_rx_start = 1'b0, i_bit_collision = 1'b0;
  logic [7:0] i_int_data = 8'h5a;
  logic [1:0] i_rate = 2'h0;
  logic i_receive_checksum_enable = 1'b0, i_crc_fail = 1'b0;
  logic i_parity_fail = 1'b0, i_sof_bad = 1'b0, i_sync_detect_enable = 1'b0;
  logic i_higher_rate_card = 1'b0, i_byte_len_bad = 1'b0, i_cmd_start = 1'b0;
  logic i_freq_in_band = 1'b0, i_checksum_compute_cmd = 1'b0;
  logic i_crc_busy = 1'b0, i_crc_done = 1'b0;
  logic i_crc_zero = 1'b0, i_timer_running = 1'b0;
  logic [7:0] i_irq_enables = 8'h00, i_irq1_flags = 8'h00;
  logic [2:0] i_modem_state = 3'h0, i_rx_last_bits = 3'h0;
  logic [79:0] i_nfcid = 80'ha9a8_a7a6_a5a4_a3a2_a1a0;
  logic o_detector_run, o_antenna_off, o_timer_start, o_timer_stop;
  logic o_irq_pending, o_initiator;
  int miscompares = 0, n_checks = 0, n_start = 0, n_stop = 0;

  // 200 MHz
  always #2.5 i_ref_clk = ~i_ref_clk;
  // count timer strobe cycles
  always @(posedge i_ref_clk) begin
    n_start <= n_start + int'(o_timer_start);
    n_stop <= n_stop + int'(o_timer_stop);
  end

  nfcsr_host_model host (.i_ref_clk, .i_rdata(o_rdata), .o_wr(i_wr),
    .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));

  nfcsr_regs #(.FIFO_DEPTH(64)) DUT (.i_ref_clk, .i_nrst, .i_ce, .i_wr,
    .i_rd, .i_addr, .i_wdata, .o_rdata, .i_mode_found, .i_rf_reset,
    .i_field_present, .i_anticollision_target_cmd, .i_tx_rx_gap,
    .i_overheat, .i_temp_below_alarm, .i_active_mode, .i_peer_field_late,
    .i_receive_framing_sel, .i_transmit_framing_sel, .i_int_push,
    .i_int_data, .i_rx_start, .i_rate, .i_bit_collision,
    .i_receive_checksum_enable, .i_crc_fail, .i_parity_fail, .i_sof_bad,
    .i_sync_detect_enable, .i_higher_rate_card, .i_byte_len_bad,
    .i_cmd_start, .i_freq_in_band, .i_checksum_compute_cmd, .i_crc_busy,
    .i_crc_done, .i_crc_zero, .i_irq_enables, .i_irq1_flags,
    .i_timer_running, .i_modem_state, .i_nfcid, .i_rx_last_bits,
    .o_detector_run, .o_antenna_off, .o_timer_start, .o_timer_stop,
    .o_irq_pending, .o_initiator);

  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // read a register, compare under a mask
  task automatic rc(input logic [5:0] a, input logic [7:0] m,
                    input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v & m, exp);
  endtask : rc
  // verdict, single exit of the run
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, well past the few hundred cycles used
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    // reset values
    rc(`NFCSR_OFF_ERR, 8'hff, 8'h00);
    rc(`NFCSR_OFF_ST2, 8'hff, 8'h00);
    rc(`NFCSR_OFF_FLVL, 8'hff, 8'h00);
    rc(`NFCSR_OFF_WMARK, 8'hff, 8'h08);
    rc(`NFCSR_OFF_CTRL, 8'hff, 8'h00);
    // clock enable low freezes the register group
    i_ce <= 1'b0;
    host.wr(`NFCSR_OFF_WMARK, 8'h05);
    i_ce <= 1'b1;
    rc(`NFCSR_OFF_WMARK, 8'hff, 8'h08);
    // order kept, empty read ignored
    for (int k = 0; k < 3; k++) host.wr(`NFCSR_OFF_FDATA, 8'h30 + 8'(k));
    rc(`NFCSR_OFF_FLVL, 8'hff, 8'h03);
    for (int k = 0; k < 3; k++) begin
      rc(`NFCSR_OFF_FDATA, 8'hff, 8'h30 + 8'(k));
    end
    rc(`NFCSR_OFF_FDATA, 8'h00, 8'h00);
    rc(`NFCSR_OFF_FLVL, 8'hff, 8'h00);
    rc(`NFCSR_OFF_ST1, 8'h03, 8'h01);
    // fill to the brim, then one host and one internal write too many
    for (int k = 0; k < 64; k++) host.wr(`NFCSR_OFF_FDATA, 8'(k));
    rc(`NFCSR_OFF_FLVL, 8'hff, 8'h40);
    rc(`NFCSR_OFF_ST1, 8'h03, 8'h02);
    host.wr(`NFCSR_OFF_FDATA, 8'hee);
    rc(`NFCSR_OFF_ERR, 8'hff, 8'h10);
    @(posedge i_ref_clk) i_cmd_start <= 1'b1;
    @(posedge i_ref_clk) i_cmd_start <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'hff, 8'h00);
    @(posedge i_ref_clk) i_int_push <= 1'b1;
    @(posedge i_ref_clk) i_int_push <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'hff, 8'h10);
    host.wr(`NFCSR_OFF_FLVL, 8'h80);
    rc(`NFCSR_OFF_FLVL, 8'hff, 8'h00);
    rc(`NFCSR_OFF_ERR, 8'hff, 8'h00);
    // host write during the anticollision command
    i_anticollision_target_cmd <= 1'b1;
    host.wr(`NFCSR_OFF_FDATA, 8'h11);
    rc(`NFCSR_OFF_ERR, 8'h80, 8'h80);
    i_anticollision_target_cmd <= 1'b0;
    host.wr(`NFCSR_OFF_FLVL, 8'h80);
    // overheat survives a command start, clear only when cool
    i_overheat <= 1'b1;
    rc(`NFCSR_OFF_ERR, 8'h40, 8'h40);
    chk({7'h00, o_antenna_off}, 8'h01);
    i_overheat <= 1'b0;
    @(posedge i_ref_clk) i_cmd_start <= 1'b1;
    @(posedge i_ref_clk) i_cmd_start <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'hff, 8'h40);
    host.wr(`NFCSR_OFF_ST2, 8'h80);
    rc(`NFCSR_OFF_ERR, 8'h40, 8'h40);
    i_temp_below_alarm <= 1'b1;
    host.wr(`NFCSR_OFF_ST2, 8'h80);
    rc(`NFCSR_OFF_ERR, 8'h40, 8'h00);
    // collision counts only at the lowest rate
    i_rate <= 2'h1;
    @(posedge i_ref_clk) i_bit_collision <= 1'b1;
    @(posedge i_ref_clk) i_bit_collision <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'h08, 8'h00);
    i_rate <= 2'h0;
    i_receive_checksum_enable <= 1'b1;
    @(posedge i_ref_clk) begin
      i_bit_collision <= 1'b1;
      i_crc_fail <= 1'b1;
    end
    @(posedge i_ref_clk) begin
      i_bit_collision <= 1'b0;
      i_crc_fail <= 1'b0;
    end
    rc(`NFCSR_OFF_ERR, 8'h08, 8'h08);
    rc(`NFCSR_OFF_ERR, 8'h04, 8'h04);
    @(posedge i_ref_clk) i_rx_start <= 1'b1;
    @(posedge i_ref_clk) i_rx_start <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'h08, 8'h00);
    rc(`NFCSR_OFF_ERR, 8'h04, 8'h00);
    // peer field timing only with active framing
    i_active_mode <= 1'b1;
    @(posedge i_ref_clk) i_peer_field_late <= 1'b1;
    @(posedge i_ref_clk) i_peer_field_late <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'h20, 8'h00);
    i_transmit_framing_sel <= `NFCSR_FRAME_ACTIVE;
    @(posedge i_ref_clk) i_peer_field_late <= 1'b1;
    @(posedge i_ref_clk) i_peer_field_late <= 1'b0;
    rc(`NFCSR_OFF_ERR, 8'h20, 8'h20);
    i_active_mode <= 1'b0;
    // second irq group: set, pending, clear
    i_irq_enables <= 8'h08;
    host.wr(`NFCSR_OFF_IRQ2, 8'h8b);
    rc(`NFCSR_OFF_IRQ2, 8'h0b, 8'h0b);
    chk({7'h00, o_irq_pending}, 8'h01);
    host.wr(`NFCSR_OFF_IRQ2, 8'h08);
    rc(`NFCSR_OFF_IRQ2, 8'h0b, 8'h03);
    chk({7'h00, o_irq_pending}, 8'h00);
    // mode detector starts on command start under the anticollision command and stops on a find
    i_anticollision_target_cmd <= 1'b1;
    @(posedge i_ref_clk) i_cmd_start <= 1'b1;
    @(posedge i_ref_clk) i_cmd_start <= 1'b0;
    @(posedge i_ref_clk) chk({7'h00, o_detector_run}, 8'h01);
    i_mode_found <= 1'b1;
    @(posedge i_ref_clk) i_mode_found <= 1'b0;
    rc(`NFCSR_OFF_IRQ2, 8'h08, 8'h08);
    chk({7'h00, o_detector_run}, 8'h00);
    i_anticollision_target_cmd <= 1'b0;
    // field and carrier pins count only after the synchroniser
    host.wr(`NFCSR_OFF_IRQ2, 8'h03);
    i_field_present <= 1'b1;
    i_freq_in_band <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    rc(`NFCSR_OFF_IRQ2, 8'h03, 8'h02);
    rc(`NFCSR_OFF_ST1, 8'h04, 8'h04);
    rc(`NFCSR_OFF_ST1, 8'h80, 8'h80);
    i_field_present <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    rc(`NFCSR_OFF_IRQ2, 8'h03, 8'h03);
    // checksum status: done with zero result, then busy again
    i_checksum_compute_cmd <= 1'b1;
    i_crc_done <= 1'b1;
    i_crc_zero <= 1'b1;
    @(posedge i_ref_clk) i_crc_done <= 1'b0;
    rc(`NFCSR_OFF_ST1, 8'h60, 8'h60);
    @(posedge i_ref_clk) i_crc_busy <= 1'b1;
    @(posedge i_ref_clk) i_crc_busy <= 1'b0;
    rc(`NFCSR_OFF_ST1, 8'h60, 8'h00);
    i_checksum_compute_cmd <= 1'b0;
    // every modem state code passes through
    for (int s = 0; s < 7; s++) begin
      i_modem_state <= 3'(s);
      rc(`NFCSR_OFF_ST2, 8'h07, 8'(s));
    end
    // timer strobes read back zero and pulse once each
    host.wr(`NFCSR_OFF_CTRL, 8'h40);
    host.wr(`NFCSR_OFF_CTRL, 8'h80);
    rc(`NFCSR_OFF_CTRL, 8'hc0, 8'h00);
    chk(8'(n_start), 8'h01);
    chk(8'(n_stop), 8'h01);
    // role bit is plain storage
    host.wr(`NFCSR_OFF_CTRL, 8'h10);
    rc(`NFCSR_OFF_CTRL, 8'h10, 8'h10);
    chk({7'h00, o_initiator}, 8'h01);
    // identifier copy lands ten bytes, low byte first
    host.wr(`NFCSR_OFF_CTRL, 8'h20);
    repeat (14) @(posedge i_ref_clk);
    rc(`NFCSR_OFF_CTRL, 8'h20, 8'h00);
    rc(`NFCSR_OFF_FLVL, 8'hff, 8'h0a);
    for (int k = 0; k < 10; k++) begin
      rc(`NFCSR_OFF_FDATA, 8'hff, 8'ha0 + 8'(k));
    end
    tally_and_finish();
  end
endmodule : test_nfcsr_regs
